// ==== mmb_pkg.sv ====
// Constants for the memory map and boot configuration block.
// Assumes an 18-bit physical space of four 64 KB segments and a 32-bit APB host.
package mmb_pkg;
    // APB register byte offsets
    localparam logic [11:0] REG_SYSTEM_CONFIGURATION_REGISTER = 12'h000;
    localparam logic [11:0] REG_DPP0 = 12'h004;
    localparam logic [11:0] REG_CSP = 12'h014;
    localparam logic [11:0] REG_STATUS = 12'h018;
    // System configuration register fields
    localparam int BUS_TYPE_FIELD_LSB = 6;
    localparam int ROM_ENABLE_STATUS_BIT = 10;
    localparam int SEGMENTATION_DISABLE_BIT = 11;
    localparam logic [1:0] BUS_TYPE_FIELD_NONE = 2'h0;
    localparam logic [1:0] BUS_TYPE_FIELD_8BIT = 2'h1;
    // Physical map, offsets within a segment
    localparam logic [15:0] ROM_TOP = 16'h1FFF;
    localparam logic [15:0] ROM_CODE_SW = 16'h1FFE;
    localparam logic [15:0] ROM_CODE_DW = 16'h1FFC;
    localparam logic [15:0] EXT0_CODE_SW = 16'hF9FE;
    localparam logic [15:0] EXT0_CODE_DW = 16'hF9FC;
    localparam logic [15:0] SEG_CODE_SW = 16'hFFFE;
    localparam logic [15:0] SEG_CODE_DW = 16'hFFFC;
    localparam logic [15:0] EXT0_TOP = 16'hF9FF;
    localparam logic [15:0] RAM_TOP = 16'hFDFF;
    localparam logic [3:0] ROM_PAGE = 4'h0;
    // Access kinds
    typedef enum logic [2:0] {
        KIND_CODE = 3'h0,
        KIND_LONG = 3'h1,
        KIND_SHORT = 3'h2,
        KIND_PEC = 3'h3,
        KIND_BIT = 3'h4
    } mmb_kind_e;
    // Fault codes reported with each answer
    localparam logic [2:0] FLT_NONE = 3'h0;
    localparam logic [2:0] FLT_ALIGN = 3'h1;
    localparam logic [2:0] FLT_MODE = 3'h2;
    localparam logic [2:0] FLT_BIT = 3'h3;
    localparam logic [2:0] FLT_EXT_OFF = 3'h4;
    localparam logic [2:0] FLT_CROSS = 3'h5;
    // Vector table spacing (log2 of bytes per entry)
    localparam int VEC_SHIFT = 2;
    // Mask ROM fill pattern; the value is arbitrary
    localparam logic [15:0] ROM_FILL = 16'hA55A;
endpackage

// ==== mmb_memory_map.sv ====
// Functional notes
// R1 - Internal ROM enabled only when both pins 0
// R2 - ROM enable status bit read-only, set at reset
// R3 - External access disabled only when both pins 0
// R4 - Bus type field loaded from pins at reset
// R5 - Software may enable external bus if reset-disabled
// R6 - Bus type field locked when reset-enabled
// R7 - 8 KB internal ROM serves code and data
// R8 - Even code fetches, ROM code ends 1FFE/1FFC
// R9 - No sequential fetch past internal ROM end
// R10 - ROM data only long/indirect via page 0
// R11 - Word data at even addresses, ROM top 1FFE
// R12 - PERIPHERAL_EVENT_CONTROLLER reaches ROM regardless of page pointer
// R13 - No bit addressing of internal ROM
// R14 - Vectors go to internal ROM when enabled
// R15 - Vectors go external when ROM disabled
// R16 - Segmentation disable restricts external to segment 0
// R17 - Segment 0 external code ends F9FE/F9FC
// R18 - Segments 1-3 end xFFFE/xFFFC; segment via jumps
// R19 - External data only long/indirect via page pointers
// R20 - PERIPHERAL_EVENT_CONTROLLER reaches external segment 0 without page pointer
// R21 - External memory 8 or 16 bits wide
// R22 - No bit addressing of external memory
// R23 - ROM disabled: lowest 8 KB is external
// R24 - Pin values held stable until next reset
//
// Address decoder, boot configuration latch and internal mask ROM.
// Assumes the CPU core presents one access at a time and holds ACC_* for a single cycle pulse.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module mmb_memory_map import mmb_pkg::*; #(
    parameter int VEC_W = 6
) (
    input wire logic CLK_IN,              // 10 MHz system clock
    input wire logic RST_IN,              // Synchronous reset, active high
    input wire logic BUS_CONFIG_PIN_HIGH_IN, // Bus configuration pin, upper
    input wire logic BUS_CONFIG_PIN_LOW_IN,  // Bus configuration pin, lower
    input wire logic PSEL_IN,             // APB select
    input wire logic PENABLE_IN,          // APB enable
    input wire logic PWRITE_IN,           // APB direction
    input wire logic [11:0] PADDR_IN,     // APB byte address
    input wire logic [31:0] PWDATA_IN,    // APB write data
    output logic [31:0] PRDATA_OUT,       // APB read data
    output logic PREADY_OUT,              // APB ready
    output logic PSLVERR_OUT,             // APB error on unmapped address
    input wire logic ACC_REQ_IN,          // Access request pulse
    input wire logic [2:0] ACC_KIND_IN,   // Access kind
    input wire logic ACC_WORD_IN,         // Word (1) or byte (0)
    input wire logic ACC_DOUBLE_IN,       // Double-word instruction fetch
    input wire logic [15:0] ACC_ADDR_IN,  // Logical address or offset
    input wire logic JUMP_SEG_IN,         // Inter-segment jump or call
    input wire logic [1:0] JUMP_SEG_SEL_IN, // Target code segment
    input wire logic VEC_REQ_IN,          // Reset, trap or interrupt vector request
    input wire logic [VEC_W-1:0] VEC_NUM_IN, // Vector number
    output logic ACC_DONE_OUT,            // Answer pulse
    output logic [17:0] ACC_PADDR_OUT,    // Physical address
    output logic ACC_ROM_OUT,             // Internal ROM selected
    output logic ACC_EXT_OUT,             // External memory selected
    output logic ACC_RAM_OUT,             // Internal RAM selected
    output logic ACC_SFR_OUT,             // Internal SFR selected
    output logic [2:0] ACC_FAULT_OUT,     // Fault code, zero when legal
    output logic [15:0] ACC_RDATA_OUT,    // Internal ROM data
    output logic VEC_DONE_OUT,            // Vector answer pulse
    output logic [17:0] VEC_ADDR_OUT,     // Vector physical address
    output logic VEC_EXT_OUT,             // Vector lies in external memory
    output logic ROM_EN_OUT,              // Internal ROM enabled
    output logic EXT_EN_OUT,              // External bus enabled
    output logic EXT_BUS16_OUT            // External bus 16 bits wide
);
    localparam int ROM_WORDS = (int'(ROM_TOP) + 1) / 2;

    initial begin
        if (VEC_W < 1 || VEC_W > 14) begin
            $error("VEC_W out of range");
        end
    end

    logic rom_enable_status;
    logic ext_locked;
    logic [1:0] bus_type_field;
    logic segmentation_disable;
    logic [3:0] data_page_pointer [4];
    logic [1:0] code_segment_pointer;
    logic [2:0] last_fault;
    logic [15:0] rom_mem [ROM_WORDS];

    // Mask-programmed contents are fixed wiring, not storage
    genvar gi;
    generate
        for (gi = 0; gi < ROM_WORDS; gi++) begin : g_rom
            assign rom_mem[gi] = ROM_FILL ^ 16'(gi); // [R7]
        end
    endgenerate

    // APB decode
    wire apb_acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    wire apb_fire = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire apb_wr = apb_fire && PWRITE_IN;
    wire hit_system_configuration_register = (PADDR_IN == REG_SYSTEM_CONFIGURATION_REGISTER);
    wire hit_csp = (PADDR_IN == REG_CSP);
    wire hit_status = (PADDR_IN == REG_STATUS);
    wire [11:0] dpp_off = PADDR_IN - REG_DPP0;
    wire hit_dpp = (PADDR_IN >= REG_DPP0) && (PADDR_IN < REG_CSP) && (PADDR_IN[1:0] == 2'h0);
    wire [1:0] dpp_idx = dpp_off[3:2];
    wire mapped = hit_system_configuration_register || hit_csp || hit_status || hit_dpp;
    wire [31:0] system_configuration_register_rd = (32'(bus_type_field) << BUS_TYPE_FIELD_LSB) | (32'(rom_enable_status) << ROM_ENABLE_STATUS_BIT)
                          | (32'(segmentation_disable) << SEGMENTATION_DISABLE_BIT);
    wire [31:0] status_rd = {29'h0, last_fault};
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_system_configuration_register) begin
            rd_mux = system_configuration_register_rd;
        end else if (hit_dpp) begin
            rd_mux = {28'h0, data_page_pointer[dpp_idx]};
        end else if (hit_csp) begin
            rd_mux = {30'h0, code_segment_pointer};
        end else if (hit_status) begin
            rd_mux = status_rd;
        end else begin
            rd_mux = 32'h0;
        end
    end

    // Pins sampled throughout reset; ROM enable and lock keep the value at release until next reset
    wire pins_both_low = !BUS_CONFIG_PIN_HIGH_IN && !BUS_CONFIG_PIN_LOW_IN;
    wire [1:0] next_bus_type_field_write = PWDATA_IN[BUS_TYPE_FIELD_LSB +: 2];
    wire bus_type_field_wr = apb_wr && hit_system_configuration_register && !ext_locked;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            rom_enable_status <= pins_both_low; // [R1] [R24]
            ext_locked <= !pins_both_low; // [R3] [R6]
            bus_type_field <= {BUS_CONFIG_PIN_HIGH_IN, BUS_CONFIG_PIN_LOW_IN}; // [R4] [R3]
        end else if (bus_type_field_wr) begin
            bus_type_field <= next_bus_type_field_write; // [R5] [R6]
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            segmentation_disable <= 1'b0;
        end else if (apb_wr && hit_system_configuration_register) begin
            segmentation_disable <= PWDATA_IN[SEGMENTATION_DISABLE_BIT]; // ROM enable bit ignored here [R2]
        end
    end

    generate
        for (gi = 0; gi < 4; gi++) begin : g_dpp
            always_ff @(posedge CLK_IN) begin
                if (RST_IN) begin
                    data_page_pointer[gi] <= 4'(gi);
                end else if (apb_wr && hit_dpp && dpp_idx == 2'(gi)) begin
                    data_page_pointer[gi] <= PWDATA_IN[3:0];
                end
            end
        end
    endgenerate

    // Code segment changes only through inter-segment branches; software cannot write it
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            code_segment_pointer <= 2'h0;
        end else if (JUMP_SEG_IN) begin
            code_segment_pointer <= JUMP_SEG_SEL_IN; // [R18]
        end
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
        end else begin
            PREADY_OUT <= apb_acc;
            PSLVERR_OUT <= apb_acc && !mapped;
            PRDATA_OUT <= (apb_acc && !PWRITE_IN) ? rd_mux : 32'h0;
        end
    end

    // Physical address formation
    wire is_code = (ACC_KIND_IN == KIND_CODE);
    wire is_pec = (ACC_KIND_IN == KIND_PEC);
    wire is_short = (ACC_KIND_IN == KIND_SHORT);
    wire is_bit = (ACC_KIND_IN == KIND_BIT);
    wire [3:0] sel_page = data_page_pointer[ACC_ADDR_IN[15:14]];
    wire [1:0] raw_seg = is_code ? code_segment_pointer
                       : is_pec ? 2'h0 // [R12] [R20]
                       : sel_page[3:2]; // [R19] [R10]
    wire [15:0] seg_off = (is_code || is_pec) ? ACC_ADDR_IN : {sel_page[1:0], ACC_ADDR_IN[13:0]};
    wire [1:0] seg = segmentation_disable ? 2'h0 : raw_seg; // [R16]
    wire [17:0] paddr = {seg, seg_off};
    wire in_seg0 = (seg == 2'h0);
    wire low_area = in_seg0 && (seg_off <= ROM_TOP);
    wire dec_rom = low_area && rom_enable_status; // [R1]
    wire dec_ram = in_seg0 && (seg_off > EXT0_TOP) && (seg_off <= RAM_TOP);
    wire dec_sfr = in_seg0 && (seg_off > RAM_TOP);
    wire dec_ext = !dec_rom && !dec_ram && !dec_sfr; // [R23]
    wire ext_enabled = (bus_type_field != BUS_TYPE_FIELD_NONE);
    wire need_even = is_code || ACC_WORD_IN;

    // Last legal fetch address of the region holding this fetch
    wire [15:0] code_sw = dec_rom ? ROM_CODE_SW : in_seg0 ? EXT0_CODE_SW : SEG_CODE_SW;
    wire [15:0] code_dw = dec_rom ? ROM_CODE_DW : in_seg0 ? EXT0_CODE_DW : SEG_CODE_DW;
    wire code_limit_ok = ACC_DOUBLE_IN ? (seg_off <= code_dw) : (seg_off <= code_sw);
    wire code_crosses = is_code && (dec_rom || dec_ext) && !code_limit_ok; // [R8] [R9] [R17] [R18]
    wire short_hit = is_short && (dec_rom || dec_ext); // [R10] [R19]
    wire bit_hit = is_bit && (dec_rom || dec_ext); // [R13] [R22]

    logic [2:0] fault;
    always_comb begin
        if (need_even && seg_off[0]) begin
            fault = FLT_ALIGN; // [R8] [R11]
        end else if (bit_hit) begin
            fault = FLT_BIT;
        end else if (short_hit) begin
            fault = FLT_MODE;
        end else if (code_crosses) begin
            fault = FLT_CROSS;
        end else if (dec_ext && !ext_enabled) begin
            fault = FLT_EXT_OFF; // [R3]
        end else begin
            fault = FLT_NONE;
        end
    end

    wire [15:0] rom_word = rom_mem[seg_off[12:1]];
    wire [15:0] rom_data = ACC_WORD_IN ? rom_word : (seg_off[0] ? {8'h0, rom_word[15:8]} : {8'h0, rom_word[7:0]});
    wire acc_ok = (fault == FLT_NONE);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ACC_DONE_OUT <= 1'b0;
            ACC_PADDR_OUT <= 18'h0;
            ACC_ROM_OUT <= 1'b0;
            ACC_EXT_OUT <= 1'b0;
            ACC_RAM_OUT <= 1'b0;
            ACC_SFR_OUT <= 1'b0;
            ACC_FAULT_OUT <= FLT_NONE;
            ACC_RDATA_OUT <= 16'h0;
        end else begin
            ACC_DONE_OUT <= ACC_REQ_IN;
            if (ACC_REQ_IN) begin
                ACC_PADDR_OUT <= paddr;
                ACC_ROM_OUT <= acc_ok && dec_rom; // [R7]
                ACC_EXT_OUT <= acc_ok && dec_ext;
                ACC_RAM_OUT <= acc_ok && dec_ram;
                ACC_SFR_OUT <= acc_ok && dec_sfr;
                ACC_FAULT_OUT <= fault;
                ACC_RDATA_OUT <= (acc_ok && dec_rom) ? rom_data : 16'h0;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            last_fault <= FLT_NONE;
        end else if (ACC_REQ_IN && !acc_ok) begin
            last_fault <= fault;
        end
    end

    // Vectors ignore the code segment pointer and always sit in segment 0
    wire [17:0] vec_addr = 18'(VEC_NUM_IN) << VEC_SHIFT;
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            VEC_DONE_OUT <= 1'b0;
            VEC_ADDR_OUT <= 18'h0;
            VEC_EXT_OUT <= 1'b0;
        end else begin
            VEC_DONE_OUT <= VEC_REQ_IN;
            if (VEC_REQ_IN) begin
                VEC_ADDR_OUT <= vec_addr; // [R14] [R15]
                VEC_EXT_OUT <= !rom_enable_status; // [R15]
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ROM_EN_OUT <= 1'b0;
            EXT_EN_OUT <= 1'b0;
            EXT_BUS16_OUT <= 1'b0;
        end else begin
            ROM_EN_OUT <= rom_enable_status;
            EXT_EN_OUT <= ext_enabled;
            EXT_BUS16_OUT <= ext_enabled && (bus_type_field != BUS_TYPE_FIELD_8BIT); // [R21]
        end
    end

    // Checks
    rom_status_fixed_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R2]
        $stable(rom_enable_status))
        else $error("ROM enable status changed outside reset");
    rom_pins_a: assert property (@(posedge CLK_IN) $fell(RST_IN) |-> // [R1]
        (rom_enable_status == !($past(BUS_CONFIG_PIN_HIGH_IN) || $past(BUS_CONFIG_PIN_LOW_IN))))
        else $error("ROM enable does not match pins");
    bus_type_field_pins_a: assert property (@(posedge CLK_IN) $fell(RST_IN) |-> // [R4]
        bus_type_field == {$past(BUS_CONFIG_PIN_HIGH_IN), $past(BUS_CONFIG_PIN_LOW_IN)})
        else $error("Bus type not loaded from pins");
    bus_type_field_lock_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R6]
        ext_locked |=> $stable(bus_type_field))
        else $error("Locked bus type changed");
    bus_type_field_write_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R5]
        (!ext_locked && apb_wr && hit_system_configuration_register) |=> bus_type_field == $past(PWDATA_IN[BUS_TYPE_FIELD_LSB +: 2]))
        else $error("Bus type write lost");
    rom_decode_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R23]
        (ACC_REQ_IN && acc_ok && low_area) |=> (ACC_ROM_OUT == rom_enable_status) && (ACC_EXT_OUT != ACC_ROM_OUT))
        else $error("Low 8 KB decoded wrongly");
    bit_refuse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R13]
        (ACC_REQ_IN && is_bit && !seg_off[0] && (dec_rom || dec_ext)) |=> ACC_DONE_OUT && ACC_FAULT_OUT == FLT_BIT)
        else $error("Bit access to ROM or external not refused");
    short_refuse_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R19]
        (ACC_REQ_IN && is_short && !seg_off[0] && dec_ext) |=> !ACC_EXT_OUT && ACC_FAULT_OUT == FLT_MODE)
        else $error("Short access reached external memory");
    seg_restrict_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R16]
        (ACC_REQ_IN && segmentation_disable) |=> ACC_PADDR_OUT[17:16] == 2'h0)
        else $error("Access left segment 0 with segmentation off");
    rom_cross_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R8]
        (ACC_REQ_IN && is_code && dec_rom && ACC_DOUBLE_IN && seg_off == ROM_CODE_SW) |=> ACC_FAULT_OUT == FLT_CROSS)
        else $error("Double fetch at ROM end not refused");
    vec_route_a: assert property (@(posedge CLK_IN) disable iff (RST_IN) // [R14]
        VEC_REQ_IN |=> VEC_DONE_OUT && VEC_EXT_OUT == !rom_enable_status && VEC_ADDR_OUT[17:16] == 2'h0)
        else $error("Vector routed wrongly");
    apb_ready_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (PSEL_IN && !PENABLE_IN) ##1 (PSEL_IN && PENABLE_IN) |=> PREADY_OUT)
        else $error("APB ready late");
endmodule

// ==== mmb_ext_mem.sv ====
// External memory model standing on the far side of the decoder.
// Assumes selects and physical address are valid while the answer pulse is high.
`timescale 1ns/1ps
module mmb_ext_mem (
    input wire logic clk_in,         // System clock
    input wire logic sel_in,         // External access answered this cycle
    input wire logic [17:0] addr_in, // Physical byte address
    input wire logic word_in,        // Word access
    input wire logic bus16_in,       // 16-bit organisation
    output logic [15:0] rdata_out,   // Read data
    output logic [1:0] cycles_out    // Bus cycles of the last access
);
    logic [15:0] idle_pat = 16'h0000;
    always_ff @(posedge clk_in) begin
        // Undeselected data lines wander so a stale value never looks valid
        idle_pat <= idle_pat + 16'h3C5B;
        if (sel_in) begin
            cycles_out <= (word_in && !bus16_in) ? 2'h2 : 2'h1;
        end
    end
    assign rdata_out = sel_in ? ~addr_in[15:0] : idle_pat;
endmodule

// ==== memory_map_boot_config_bench.sv ====
// Self-checking bench for the memory map and boot configuration block.
// Assumes the design answers APB with one wait state and accesses one cycle after the request.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); n_errors++; end end
module memory_map_boot_config_bench import mmb_pkg::*;;
    logic clk_in, rst_in, pin_hi, pin_lo, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic acc_req, acc_word, acc_dbl, jump, vec_req, done, rom, ext, ram, sfr;
    logic vdone, vext, rom_en, ext_en, bus16;
    logic [2:0] acc_kind, fault;
    logic [15:0] acc_addr, rdata, m_rdata;
    logic [1:0] jsel, m_cycles;
    logic [5:0] vec_num;
    logic [17:0] a_paddr, vaddr;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    mmb_memory_map #(.VEC_W(6)) dut (.CLK_IN(clk_in), .RST_IN(rst_in),
        .BUS_CONFIG_PIN_HIGH_IN(pin_hi), .BUS_CONFIG_PIN_LOW_IN(pin_lo), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ACC_REQ_IN(acc_req),
        .ACC_KIND_IN(acc_kind), .ACC_WORD_IN(acc_word), .ACC_DOUBLE_IN(acc_dbl), .ACC_ADDR_IN(acc_addr),
        .JUMP_SEG_IN(jump), .JUMP_SEG_SEL_IN(jsel), .VEC_REQ_IN(vec_req), .VEC_NUM_IN(vec_num),
        .ACC_DONE_OUT(done), .ACC_PADDR_OUT(a_paddr), .ACC_ROM_OUT(rom), .ACC_EXT_OUT(ext),
        .ACC_RAM_OUT(ram), .ACC_SFR_OUT(sfr), .ACC_FAULT_OUT(fault), .ACC_RDATA_OUT(rdata),
        .VEC_DONE_OUT(vdone), .VEC_ADDR_OUT(vaddr), .VEC_EXT_OUT(vext), .ROM_EN_OUT(rom_en),
        .EXT_EN_OUT(ext_en), .EXT_BUS16_OUT(bus16));
    mmb_ext_mem ext_mem (.clk_in(clk_in), .sel_in(done & ext), .addr_in(a_paddr), .word_in(acc_word),
        .bus16_in(bus16), .rdata_out(m_rdata), .cycles_out(m_cycles));
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    task conclude;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end
    task do_reset(input logic hi, input logic lo);
        @(posedge clk_in);
        rst_in <= 1'b1;
        pin_hi <= hi;
        pin_lo <= lo;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // Request stands until the edge that samples ready high; data taken there
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task acc(input logic [2:0] k, input logic dbl, input logic [15:0] a, input logic [2:0] f,
             input logic r, input logic x, input logic [17:0] pa);
        @(posedge clk_in);
        acc_req <= 1'b1;
        acc_kind <= k;
        acc_dbl <= dbl;
        acc_addr <= a;
        @(posedge clk_in);
        acc_req <= 1'b0;
        @(negedge clk_in);
        `CHK("acc_done", 1'b1, done)
        `CHK("acc_fault", f, fault)
        `CHK("acc_rom", r, rom)
        `CHK("acc_ext", x, ext)
        if (f == FLT_NONE) `CHK("acc_paddr", pa, a_paddr)
    endtask
    task vec(input logic [5:0] n, input logic x);
        @(posedge clk_in);
        vec_req <= 1'b1;
        vec_num <= n;
        @(posedge clk_in);
        vec_req <= 1'b0;
        @(negedge clk_in);
        `CHK("vec_done", 1'b1, vdone)
        `CHK("vec_addr", {10'h000, n, 2'h0}, vaddr)
        `CHK("vec_ext", x, vext)
    endtask
    initial begin
        {rst_in, pin_hi, pin_lo, psel, penable, pwrite, acc_req, acc_dbl, jump, vec_req} = 10'h200;
        {paddr, pwdata, acc_kind, acc_addr, jsel, vec_num} = '0;
        acc_word = 1'b1;
        for (int p = 0; p < 4; p++) begin
            do_reset(p[1], p[0]);
            pin_hi <= ~p[1];
            pin_lo <= ~p[0];
            @(negedge clk_in);
            `CHK("rom_en", p == 0, rom_en)
            `CHK("ext_en", p != 0, ext_en)
            `CHK("bus16", p[1], bus16)
            apb(1'b0, REG_SYSTEM_CONFIGURATION_REGISTER, 32'h0);
            `CHK("system_configuration_register_bus_type_field", p[1:0], rd[7:6])
            `CHK("system_configuration_register_rom_enable_status", p == 0, rd[ROM_ENABLE_STATUS_BIT])
            apb(1'b1, REG_SYSTEM_CONFIGURATION_REGISTER, 32'h000004C0 ^ (rd & 32'h00000400));
            apb(1'b0, REG_SYSTEM_CONFIGURATION_REGISTER, 32'h0);
            `CHK("rom_enable_status_kept", p == 0, rd[ROM_ENABLE_STATUS_BIT])
            `CHK("bus_type_field_written", (p == 0) ? 2'h3 : p[1:0], rd[7:6])
            `CHK("rom_en_held", p == 0, rom_en)
            vec(6'h03, p != 0);
            acc(KIND_CODE, 1'b0, 16'h0000, FLT_NONE, p == 0, p != 0, 18'h00000);
        end
        do_reset(1'b0, 1'b0);
        acc(KIND_CODE, 1'b0, 16'h1FFE, FLT_NONE, 1'b1, 1'b0, 18'h01FFE);
        acc(KIND_CODE, 1'b1, 16'h1FFE, FLT_CROSS, 1'b0, 1'b0, 18'h0);
        acc(KIND_CODE, 1'b1, 16'h1FFC, FLT_NONE, 1'b1, 1'b0, 18'h01FFC);
        acc(KIND_CODE, 1'b0, 16'h0001, FLT_ALIGN, 1'b0, 1'b0, 18'h0);
        acc(KIND_LONG, 1'b0, 16'h0003, FLT_ALIGN, 1'b0, 1'b0, 18'h0);
        acc(KIND_LONG, 1'b0, 16'h1FFE, FLT_NONE, 1'b1, 1'b0, 18'h01FFE);
        acc(KIND_LONG, 1'b0, 16'h0004, FLT_NONE, 1'b1, 1'b0, 18'h00004);
        `CHK("rom_word", ROM_FILL ^ 16'h0002, rdata)
        @(posedge clk_in);
        acc_word <= 1'b0;
        acc(KIND_LONG, 1'b0, 16'h0005, FLT_NONE, 1'b1, 1'b0, 18'h00005);
        `CHK("rom_byte", 16'h00A5, rdata)
        @(posedge clk_in);
        acc_word <= 1'b1;
        acc(KIND_SHORT, 1'b0, 16'h0100, FLT_MODE, 1'b0, 1'b0, 18'h0);
        acc(KIND_BIT, 1'b0, 16'h0100, FLT_BIT, 1'b0, 1'b0, 18'h0);
        acc(KIND_LONG, 1'b0, 16'h2000, FLT_EXT_OFF, 1'b0, 1'b0, 18'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("status_fault", FLT_EXT_OFF, rd[2:0])
        apb(1'b1, REG_DPP0, 32'h5);
        acc(KIND_LONG, 1'b0, 16'h0100, FLT_EXT_OFF, 1'b0, 1'b0, 18'h0);
        acc(KIND_PEC, 1'b0, 16'h0100, FLT_NONE, 1'b1, 1'b0, 18'h00100);
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        apb(1'b1, REG_SYSTEM_CONFIGURATION_REGISTER, 32'h00000040);
        acc(KIND_PEC, 1'b0, 16'h3000, FLT_NONE, 1'b0, 1'b1, 18'h03000);
        `CHK("ext_rdata", 16'hCFFF, m_rdata)
        @(negedge clk_in);
        `CHK("ext_cycles_8", 2'h2, m_cycles)
        acc(KIND_CODE, 1'b0, 16'hF9FE, FLT_NONE, 1'b0, 1'b1, 18'h0F9FE);
        acc(KIND_CODE, 1'b1, 16'hF9FE, FLT_CROSS, 1'b0, 1'b0, 18'h0);
        acc(KIND_CODE, 1'b1, 16'hF9FC, FLT_NONE, 1'b0, 1'b1, 18'h0F9FC);
        acc(KIND_SHORT, 1'b0, 16'h2000, FLT_MODE, 1'b0, 1'b0, 18'h0);
        acc(KIND_BIT, 1'b0, 16'h2000, FLT_BIT, 1'b0, 1'b0, 18'h0);
        @(posedge clk_in);
        jump <= 1'b1;
        jsel <= 2'h2;
        @(posedge clk_in);
        jump <= 1'b0;
        acc(KIND_CODE, 1'b0, 16'hFFFE, FLT_NONE, 1'b0, 1'b1, 18'h2FFFE);
        acc(KIND_CODE, 1'b1, 16'hFFFE, FLT_CROSS, 1'b0, 1'b0, 18'h0);
        apb(1'b1, REG_CSP, 32'h1);
        apb(1'b0, REG_CSP, 32'h0);
        `CHK("csp_value", 2'h2, rd[1:0])
        apb(1'b1, REG_SYSTEM_CONFIGURATION_REGISTER, 32'h00000880);
        acc(KIND_CODE, 1'b0, 16'h2000, FLT_NONE, 1'b0, 1'b1, 18'h02000);
        acc(KIND_LONG, 1'b0, 16'h0100, FLT_NONE, 1'b0, 1'b1, 18'h04100);
        @(negedge clk_in);
        `CHK("bus16_sw", 1'b1, bus16)
        `CHK("ext_cycles_16", 2'h1, m_cycles)
        conclude();
    end
endmodule
